// ### sfe_busy_timer.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_busy_timer #(
    parameter int CYCLES = sfe_pkg::BUSY_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic start_in,
    output logic busy_out,
    output logic done_out
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] cnt;
    } sfe_timer_t;

    sfe_timer_t t_r;
    sfe_timer_t t_nxt;

    always_comb begin
        t_nxt = t_r;
        t_nxt.done = 1'b0;
        if (!t_r.busy) begin
            if (start_in) begin
                t_nxt.busy = 1'b1;
                t_nxt.cnt = LOAD;
            end
        end else if (t_r.cnt <= CW'(1)) begin
            // Runs on whatever chip select does
            t_nxt.busy = 1'b0;
            t_nxt.done = 1'b1;
            t_nxt.cnt = '0;
        end else begin
            t_nxt.cnt = t_r.cnt - CW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            t_r <= '0;
        end else if (ce_in) begin
            t_r <= t_nxt;
        end
    end

    assign busy_out = t_r.busy;
    assign done_out = t_r.done;
endmodule
`default_nettype wire

// ### sfe_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_checker #(
    parameter int BUSY_CYCLES = sfe_pkg::BUSY_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic cs_n_in,
    input wire logic [3:0] data_line_oe_out,
    input wire logic op_start_out,
    input wire logic busy_out,
    input wire logic quad_mode_enable_out,
    input wire logic selected_out,
    input wire logic paused_out
);
    int busy_r;
    always_ff @(posedge clk_in) busy_r <= busy_out ? busy_r + 1 : 0;
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    idle_release_a: assert property (cs_n_in [*5] |-> data_line_oe_out == 4'h0)
        else $error("drive while deselected");
    idle_deselect_a: assert property (cs_n_in [*5] |-> !selected_out && !paused_out)
        else $error("selected while high");
    lane_set_a: assert property (data_line_oe_out inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("bad lane set");
    quad_gate_a: assert property (data_line_oe_out[3] |-> quad_mode_enable_out)
        else $error("quad without enable");
    pause_quiet_a: assert property (paused_out [*2] |-> data_line_oe_out == 4'h0)
        else $error("drive while paused");
    pause_mode_a: assert property (paused_out |-> !quad_mode_enable_out)
        else $error("pause in quad");
    pause_select_a: assert property ($rose(paused_out) |-> selected_out)
        else $error("pause unselected");
    busy_start_a: assert property (op_start_out |=> busy_out [*8])
        else $error("busy missing");
    busy_len_a: assert property ($fell(busy_out) |-> busy_r == BUSY_CYCLES)
        else $error("busy length");
endmodule
`default_nettype wire

// ### sfe_front_end.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_front_end #(
    parameter int BUSY_CYCLES = sfe_pkg::BUSY_CYCLES_DEF
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic [3:0] data_line_in,
    output logic [3:0] data_line_out,
    output logic [3:0] data_line_oe_out,
    input wire logic [7:0] rd_data_in,
    output logic [23:0] rd_addr_out,
    output logic pgm_valid_out,
    output logic [7:0] pgm_data_out,
    output logic [23:0] pgm_addr_out,
    output logic op_start_out,
    output logic [7:0] op_code_out,
    output logic [23:0] op_addr_out,
    output logic busy_out,
    output logic quad_mode_enable_out,
    output logic selected_out,
    output logic paused_out
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        sfe_pkg::sfe_phase_t phase;
        logic cs_q;
        logic sclk_q;
        logic cmd_ok;
        logic [7:0] opcode;
        sfe_pkg::sfe_decode_t dec;
        logic [31:0] shin;
        logic [5:0] cnt;
        logic [23:0] addr;
        logic [7:0] obuf;
        logic [2:0] obit;
        logic [2:0] ibit;
        logic drv;
        logic paused;
        logic sel;
        logic wel;
        logic [15:0] sr_nv;
        logic [15:0] sr_wbuf;
        logic [15:0] sr_pend;
        logic [1:0] wr_bytes;
        logic [3:0] dout;
        logic [3:0] doe;
        logic pgm_valid;
        logic [7:0] pgm_data;
        logic [23:0] pgm_addr;
        logic op_start;
        logic [7:0] op_code;
        logic [23:0] op_addr;
    } sfe_core_t;

    sfe_core_t c_r;
    sfe_core_t c_nxt;
    sfe_pkg::sfe_pins_t pins;
    logic busy;
    logic op_done;

    ////////////////////////////////////////////////////////////////////////////

    // Every pin is outside the clock domain
    sfe_sync2 #(
        .W(6)
    ) u_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .d_in({cs_n_in, sclk_in, data_line_in}),
        .q_out(pins)
    );

    sfe_busy_timer #(
        .CYCLES(BUSY_CYCLES)
    ) u_timer (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .start_in(c_r.op_start),
        .busy_out(busy),
        .done_out(op_done)
    );

    ////////////////////////////////////////////////////////////////////////////

    function automatic sfe_pkg::sfe_decode_t decode(input logic [7:0] op, input logic qe);
        sfe_pkg::sfe_decode_t d;
        d = '0;
        d.addr_w = sfe_pkg::LANE_1;
        d.addr_bits = sfe_pkg::ADDR_BITS;
        d.out_w = sfe_pkg::LANE_1;
        case (op)
            sfe_pkg::OP_WREN, sfe_pkg::OP_WRDI: begin
                d.valid = 1'b1;
            end
            sfe_pkg::OP_RDSR1, sfe_pkg::OP_RDSR2: begin
                d.valid = 1'b1;
                d.allow_busy = 1'b1;
                d.is_read = 1'b1;
                d.src = (op == sfe_pkg::OP_RDSR1) ? 2'h1 : 2'h2;
            end
            sfe_pkg::OP_WRSR: begin
                d.valid = 1'b1;
                d.is_din = 1'b1;
            end
            sfe_pkg::OP_READ, sfe_pkg::OP_FAST: begin
                d.valid = 1'b1;
                d.has_addr = 1'b1;
                d.is_read = 1'b1;
                d.dummy = (op == sfe_pkg::OP_FAST) ? sfe_pkg::DUMMY_FAST : 4'h0;
            end
            sfe_pkg::OP_DOUT, sfe_pkg::OP_DIO: begin
                d.valid = 1'b1;
                d.has_addr = 1'b1;
                d.is_read = 1'b1;
                d.out_w = sfe_pkg::LANE_2;
                if (op == sfe_pkg::OP_DIO) begin
                    d.addr_w = sfe_pkg::LANE_2;
                    d.addr_bits = sfe_pkg::ADDR_MODE_BITS;
                end else begin
                    d.dummy = sfe_pkg::DUMMY_FAST;
                end
            end
            sfe_pkg::OP_QOUT, sfe_pkg::OP_QIO: begin
                d.valid = qe;
                d.has_addr = 1'b1;
                d.is_read = 1'b1;
                d.out_w = sfe_pkg::LANE_4;
                if (op == sfe_pkg::OP_QIO) begin
                    d.addr_w = sfe_pkg::LANE_4;
                    d.addr_bits = sfe_pkg::ADDR_MODE_BITS;
                    d.dummy = sfe_pkg::DUMMY_QIO;
                end else begin
                    d.dummy = sfe_pkg::DUMMY_FAST;
                end
            end
            sfe_pkg::OP_PP: begin
                d.valid = 1'b1;
                d.has_addr = 1'b1;
                d.is_din = 1'b1;
                d.is_op = 1'b1;
            end
            sfe_pkg::OP_SE, sfe_pkg::OP_BE32, sfe_pkg::OP_BE64: begin
                d.valid = 1'b1;
                d.has_addr = 1'b1;
                d.is_op = 1'b1;
            end
            sfe_pkg::OP_CE1, sfe_pkg::OP_CE2: begin
                d.valid = 1'b1;
                d.is_op = 1'b1;
            end
            default: begin
                d.valid = 1'b0;
            end
        endcase
        return d;
    endfunction

    function automatic logic [3:0] lanes_in(input logic [2:0] w, input logic [3:0] dl);
        case (w)
            sfe_pkg::LANE_2: lanes_in = {2'h0, dl[1:0]};
            sfe_pkg::LANE_4: lanes_in = dl;
            default: lanes_in = {3'h0, dl[0]};
        endcase
    endfunction

    function automatic logic [3:0] lanes_out(input logic [2:0] w, input logic [7:0] b);
        case (w)
            sfe_pkg::LANE_2: lanes_out = {2'h0, b[7:6]};
            sfe_pkg::LANE_4: lanes_out = b[7:4];
            default: lanes_out = {2'h0, b[7], 1'b0};
        endcase
    endfunction

    function automatic logic [3:0] lane_mask(input logic [2:0] w);
        case (w)
            sfe_pkg::LANE_2: lane_mask = 4'h3;
            sfe_pkg::LANE_4: lane_mask = 4'hF;
            default: lane_mask = 4'h2;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    logic hold_ok;
    logic active;
    logic wp_eff;
    logic wr_allowed;
    logic [31:0] sh;
    logic [5:0] step;
    logic [7:0] ob;
    logic [7:0] status_lo;
    logic [7:0] src_byte;
    sfe_pkg::sfe_decode_t dn;

    always_comb begin
        c_nxt = c_r;
        sh = c_r.shin;
        step = 6'h0;
        ob = c_r.obuf;
        dn = c_r.dec;
        rise = pins.sclk & ~c_r.sclk_q;
        fall = ~pins.sclk & c_r.sclk_q;
        // reset leaves cs_q low, so only a real fall from high selects
        cs_fall = ~pins.cs_n & c_r.cs_q;
        cs_rise = pins.cs_n & ~c_r.cs_q;
        active = ~pins.cs_n & ~c_r.paused;
        status_lo = {c_r.sr_nv[7:2], c_r.wel, busy};
        case (c_r.dec.src)
            2'h1: src_byte = status_lo;
            2'h2: src_byte = c_r.sr_nv[15:8];
            default: src_byte = rd_data_in;
        endcase
        // quad mode takes the pin away from write protect
        wp_eff = c_r.sr_nv[sfe_pkg::SR_QE] | pins.dl[2];
        wr_allowed = ({c_r.sr_nv[sfe_pkg::SR_SRP1], c_r.sr_nv[sfe_pkg::SR_SRP0]}
                      == sfe_pkg::SRP_SOFT) ||
                     (({c_r.sr_nv[sfe_pkg::SR_SRP1], c_r.sr_nv[sfe_pkg::SR_SRP0]}
                      == sfe_pkg::SRP_HARD) && wp_eff);
        c_nxt.cs_q = pins.cs_n;
        c_nxt.sclk_q = pins.sclk;
        c_nxt.pgm_valid = 1'b0;
        c_nxt.op_start = 1'b0;

        // commit only when the timed cycle ends
        if (op_done && c_r.op_code == sfe_pkg::OP_WRSR) begin
            c_nxt.sr_nv = (c_r.sr_nv & ~sfe_pkg::SR_NV_MASK) |
                          (c_r.sr_pend & sfe_pkg::SR_NV_MASK);
        end

        // pin is data line 3 in quad mode; only while selected
        hold_ok = ~c_r.sr_nv[sfe_pkg::SR_QE] & ~pins.cs_n & c_r.sel;
        // pause follows the pin only while the clock is low
        if (!hold_ok) begin
            c_nxt.paused = 1'b0;
        end else if (!pins.sclk) begin
            c_nxt.paused = ~pins.dl[3];
        end

        if (cs_rise) begin
            if (c_r.cmd_ok) begin
                if (c_r.opcode == sfe_pkg::OP_WREN) begin
                    c_nxt.wel = 1'b1;
                end else if (c_r.opcode == sfe_pkg::OP_WRDI) begin
                    c_nxt.wel = 1'b0;
                end else if (c_r.opcode == sfe_pkg::OP_WRSR) begin
                    if (c_r.wel && c_r.wr_bytes != 2'h0 && c_r.ibit == 3'h0 && wr_allowed) begin
                        c_nxt.op_start = 1'b1;
                        c_nxt.op_code = c_r.opcode;
                        c_nxt.sr_pend = c_r.sr_wbuf;
                        c_nxt.wel = 1'b0;
                    end
                end else if (c_r.dec.is_op && c_r.wel && c_r.ibit == 3'h0 &&
                             (c_r.phase == sfe_pkg::ST_DONE || c_r.phase == sfe_pkg::ST_DIN)) begin
                    c_nxt.op_start = 1'b1;
                    c_nxt.op_code = c_r.opcode;
                    c_nxt.op_addr = c_r.addr;
                    c_nxt.wel = 1'b0;
                end
            end
            // deselect clears instruction and shift state
            c_nxt.phase = sfe_pkg::ST_WAIT;
            c_nxt.cmd_ok = 1'b0;
            c_nxt.cnt = 6'h0;
            c_nxt.ibit = 3'h0;
            c_nxt.obit = 3'h0;
            c_nxt.drv = 1'b0;
            c_nxt.paused = 1'b0;
            c_nxt.sel = 1'b0;
        end else if (cs_fall) begin
            c_nxt.sel = 1'b1;
            c_nxt.phase = sfe_pkg::ST_CMD;
            c_nxt.cnt = 6'h0;
            c_nxt.shin = 32'h0;
            c_nxt.wr_bytes = 2'h0;
        end else if (active && rise) begin
            // state is only touched by unpaused edges, so a pause resumes in place
            case (c_r.phase)
                sfe_pkg::ST_CMD: begin
                    // opcode MSB first on data line 0
                    sh = {c_r.shin[30:0], pins.dl[0]};
                    c_nxt.shin = sh;
                    c_nxt.cnt = c_r.cnt + 6'h1;
                    if (c_r.cnt == sfe_pkg::OPCODE_LAST) begin
                        dn = decode(sh[7:0], c_r.sr_nv[sfe_pkg::SR_QE]);
                        c_nxt.opcode = sh[7:0];
                        c_nxt.dec = dn;
                        c_nxt.cnt = 6'h0;
                        c_nxt.shin = 32'h0;
                        c_nxt.cmd_ok = dn.valid & (dn.allow_busy | ~busy);
                        c_nxt.sr_wbuf = c_r.sr_nv;
                        if (!(dn.valid && (dn.allow_busy || !busy))) begin
                            c_nxt.phase = sfe_pkg::ST_DONE;
                        end else if (dn.has_addr) begin
                            c_nxt.phase = sfe_pkg::ST_ADDR;
                        end else if (dn.is_read) begin
                            c_nxt.phase = sfe_pkg::ST_DOUT;
                        end else if (dn.is_din) begin
                            c_nxt.phase = sfe_pkg::ST_DIN;
                        end else begin
                            c_nxt.phase = sfe_pkg::ST_DONE;
                        end
                    end
                end
                sfe_pkg::ST_ADDR: begin
                    step = {3'h0, c_r.dec.addr_w};
                    sh = (c_r.shin << c_r.dec.addr_w) |
                         {28'h0, lanes_in(c_r.dec.addr_w, pins.dl)};
                    c_nxt.shin = sh;
                    c_nxt.cnt = c_r.cnt + step;
                    if (c_r.cnt + step == c_r.dec.addr_bits) begin
                        c_nxt.addr = (c_r.dec.addr_bits == sfe_pkg::ADDR_MODE_BITS) ?
                                     sh[31:8] : sh[23:0];
                        c_nxt.cnt = 6'h0;
                        if (c_r.dec.dummy != 4'h0) begin
                            c_nxt.phase = sfe_pkg::ST_DUMMY;
                        end else if (c_r.dec.is_read) begin
                            c_nxt.phase = sfe_pkg::ST_DOUT;
                        end else if (c_r.dec.is_din) begin
                            c_nxt.phase = sfe_pkg::ST_DIN;
                        end else begin
                            c_nxt.phase = sfe_pkg::ST_DONE;
                        end
                    end
                end
                sfe_pkg::ST_DUMMY: begin
                    c_nxt.cnt = c_r.cnt + 6'h1;
                    if (c_r.cnt + 6'h1 == {2'h0, c_r.dec.dummy}) begin
                        c_nxt.cnt = 6'h0;
                        c_nxt.phase = sfe_pkg::ST_DOUT;
                    end
                end
                sfe_pkg::ST_DIN: begin
                    sh = {c_r.shin[30:0], pins.dl[0]};
                    c_nxt.shin = sh;
                    c_nxt.ibit = c_r.ibit + 3'h1;
                    if (c_r.ibit == sfe_pkg::BYTE_LAST) begin
                        if (c_r.opcode == sfe_pkg::OP_WRSR) begin
                            if (c_r.wr_bytes == 2'h0) begin
                                c_nxt.sr_wbuf[7:0] = sh[7:0];
                                c_nxt.wr_bytes = 2'h1;
                            end else if (c_r.wr_bytes == 2'h1) begin
                                c_nxt.sr_wbuf[15:8] = sh[7:0];
                                c_nxt.wr_bytes = 2'h2;
                            end
                        end else begin
                            // Page wraps inside its 256 bytes
                            c_nxt.pgm_valid = 1'b1;
                            c_nxt.pgm_data = sh[7:0];
                            c_nxt.pgm_addr = c_r.addr;
                            c_nxt.addr = {c_r.addr[23:8], c_r.addr[7:0] + 8'h01};
                        end
                    end
                end
                default: begin
                    c_nxt.phase = c_r.phase;
                end
            endcase
        end else if (active && fall && c_r.phase == sfe_pkg::ST_DOUT) begin
            // output changes only on the falling clock
            ob = (c_r.obit == 3'h0) ? src_byte : c_r.obuf;
            c_nxt.dout = lanes_out(c_r.dec.out_w, ob);
            c_nxt.obuf = ob << c_r.dec.out_w;
            c_nxt.obit = c_r.obit + c_r.dec.out_w;
            c_nxt.drv = 1'b1;
            if (c_r.obit + c_r.dec.out_w == 3'h0 && c_r.dec.src == 2'h0) begin
                c_nxt.addr = c_r.addr + 24'h000001;
            end
        end

        // release every line when deselected or paused
        if (!pins.cs_n && !c_nxt.paused && c_nxt.drv && c_nxt.phase == sfe_pkg::ST_DOUT) begin
            c_nxt.doe = lane_mask(c_r.dec.out_w);
        end else begin
            c_nxt.doe = 4'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            c_r <= '0;
            c_r.phase <= sfe_pkg::ST_WAIT;
            c_r.sr_nv <= sfe_pkg::SR_RESET;
        end else if (ce_in) begin
            c_r <= c_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign data_line_out = c_r.dout;
    assign data_line_oe_out = c_r.doe;
    assign rd_addr_out = c_r.addr;
    assign pgm_valid_out = c_r.pgm_valid;
    assign pgm_data_out = c_r.pgm_data;
    assign pgm_addr_out = c_r.pgm_addr;
    assign op_start_out = c_r.op_start;
    assign op_code_out = c_r.op_code;
    assign op_addr_out = c_r.op_addr;
    assign busy_out = busy;
    assign quad_mode_enable_out = c_r.sr_nv[sfe_pkg::SR_QE];
    assign selected_out = c_r.sel;
    assign paused_out = c_r.paused;

endmodule
`default_nettype wire

// ### sfe_front_end_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_front_end_tb;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic cs_n_in, sclk_in, op_start_out, busy_out, quad_mode_enable_out, paused_out;
    logic [3:0] data_line_in, data_line_out, data_line_oe_out, oe;
    logic [7:0] op_code_out, b;
    logic [23:0] rd_addr_out, op_addr_out, a;
    logic [31:0] sop;
    logic [15:0] rx;
    int fail_count = 0;
    int check_count = 0;
    int pz = 0;
    always #50 clk_in = ~clk_in;
    sfe_front_end #(.BUSY_CYCLES(20)) i_sfe_front_end (.clk_in, .srst_in, .ce_in(1'b1), .cs_n_in,
        .sclk_in, .data_line_in, .data_line_out, .data_line_oe_out, .rd_addr_out,
        .rd_data_in(rd_addr_out[7:0] ^ 8'hA5), .pgm_valid_out(), .pgm_data_out(),
        .pgm_addr_out(), .op_start_out, .op_code_out, .op_addr_out, .busy_out,
        .quad_mode_enable_out, .selected_out(), .paused_out);
    sfe_spi_master i_sfe_spi_master (.clk_in, .data_line_out, .data_line_oe_out,
        .cs_n_out(cs_n_in), .sclk_out(sclk_in), .line_out(data_line_in));
    always @(posedge clk_in) begin
        pz <= pz + int'(paused_out === 1'b1);
        if (op_start_out === 1'b1) sop <= {op_code_out, op_addr_out};
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] e, input logic [31:0] g, input string s);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic go(input logic [31:0] tx, input int nt = 8, input int nr = 16,
                      input int w = 1, input bit m3 = 0, input bit p = 0);
        i_sfe_spi_master.xfer(m3, tx, nt, nr, w, p, rx, oe);
        for (int i = 0; i < 60 && (i < 3 || busy_out !== 1'b0); i++) @(posedge clk_in);
        if (busy_out !== 1'b0) fail_count++;
    endtask
    function automatic logic [15:0] rd_pair(input logic [23:0] ad);
        return {ad[7:0] ^ 8'hA5, (ad[7:0] + 8'h01) ^ 8'hA5};
    endfunction
    initial begin
        #4000000;
        fail_count++;
        complete_run();
    end
    initial begin
        void'($urandom(28));
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        go(32'h05000000);
        chk(0, oe, "unarmed lanes");
        go(32'h05000000, 8, 16, 1, 1, 1);
        chk(16'h0, rx, "paused status");
        chk(4'h2, oe, "status lanes");
        chk(1, pz > 2, "paused");
        go(32'h06000000, 8, 0);
        go(32'h05000000);
        chk(16'h0202, rx, "write latch");
        b = 8'($urandom) & 8'h7C;
        go({8'h01, b, 16'h0200}, 24, 0);
        chk(8'h01, sop[31:24], "status write");
        go(32'h05000000);
        chk({b, b}, rx, "status1");
        go(32'h35000000);
        chk({16'h0202, 1'b1}, {rx, quad_mode_enable_out}, "status2");
        for (int k = 0; k < 3; k++) begin
            a = 24'($urandom);
            go({(k == 0) ? 8'h6B : (k == 1) ? 8'h3B : 8'h03, a}, 32, (k == 0) ? 12 : 16,
               4 >> k, k == 2);
            chk(rd_pair(a), rx, "read data");
            chk((k == 0) ? 4'hF : (k == 1) ? 4'h3 : 4'h2, oe, "read lanes");
        end
        go(32'h06000000, 8, 0);
        go({8'h20, a}, 32, 0);
        chk({8'h20, a}, sop, "erase start");
        go(32'h06000000, 8, 0);
        go(32'h01000000, 24, 0);
        go({8'h6B, a}, 32, 12, 4);
        chk(0, oe, "quad refused");
        complete_run();
    end
endmodule
bind sfe_front_end sfe_checker #(.BUSY_CYCLES(BUSY_CYCLES)) i_sfe_checker (.clk_in, .srst_in,
    .cs_n_in, .data_line_oe_out, .op_start_out, .busy_out, .quad_mode_enable_out,
    .selected_out, .paused_out);
`default_nettype wire

// ### sfe_pkg.sv
// Behaviour
// - Chip select high deselects; every data line output is released.
// - Chip select low selects; instructions, address, data accepted, read data returned.
// - After reset nothing is accepted until chip select falls from high.
// - A started erase, program or status write runs to its end regardless of select.
// - Single-line input sampled on data line 0 at each rising serial clock.
// - Single-line output driven on data line 1, changing at falling serial clock.
// - Dual and quad lines sample on rising and drive on falling serial clock.
// - Clock modes 0 and 3 only; master idles clock low or high at select edges.
// - Dual read opcodes turn data lines 0 and 1 into two-way lines.
// - Quad read opcodes use all four data lines as two-way lines.
// - Four-line opcodes work only with quad mode enabled; pins become lines 2 and 3.
// - Active-low write protect, with protect mode, blocks status register writes.
// - With quad mode enabled the write protect function is not applied.
// - Pause works in single and dual operation only, never in quad.
// - Pause takes effect only while chip select is low.
// - Pause starts at pause-pin fall if clock low, else after next clock fall.
// - Pause ends at pause-pin rise if clock low, else after next clock fall.
// - While paused, outputs released; serial input and clock ignored.
// - Pause keeps partial instruction and page data; transfer resumes where it stopped.
// - Quad mode enable is non-volatile status bit 9, cleared by default.
package sfe_pkg;

    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0B;
    localparam logic [7:0] OP_DOUT = 8'h3B;
    localparam logic [7:0] OP_DIO = 8'hBB;
    localparam logic [7:0] OP_QOUT = 8'h6B;
    localparam logic [7:0] OP_QIO = 8'hEB;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hD8;
    localparam logic [7:0] OP_CE1 = 8'hC7;
    localparam logic [7:0] OP_CE2 = 8'h60;

    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_SRP0 = 7;
    localparam int SR_SRP1 = 8;
    localparam int SR_QE = 9;
    localparam logic [15:0] SR_RESET = 16'h0000;
    localparam logic [15:0] SR_NV_MASK = 16'h03FC;
    localparam logic [1:0] SRP_SOFT = 2'h0;
    localparam logic [1:0] SRP_HARD = 2'h1;

    localparam logic [2:0] LANE_1 = 3'h1;
    localparam logic [2:0] LANE_2 = 3'h2;
    localparam logic [2:0] LANE_4 = 3'h4;
    localparam logic [5:0] ADDR_BITS = 6'h18;
    localparam logic [5:0] ADDR_MODE_BITS = 6'h20;
    localparam logic [3:0] DUMMY_FAST = 4'h8;
    localparam logic [3:0] DUMMY_QIO = 4'h4;
    localparam logic [5:0] OPCODE_LAST = 6'h07;
    localparam logic [2:0] BYTE_LAST = 3'h7;

    localparam int BUSY_CYCLES_DEF = 1000;

    typedef enum logic [6:0] {
        ST_WAIT = 7'h01,
        ST_CMD = 7'h02,
        ST_ADDR = 7'h04,
        ST_DUMMY = 7'h08,
        ST_DIN = 7'h10,
        ST_DOUT = 7'h20,
        ST_DONE = 7'h40
    } sfe_phase_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] dl;
    } sfe_pins_t;

    typedef struct packed {
        logic valid;
        logic allow_busy;
        logic has_addr;
        logic [2:0] addr_w;
        logic [5:0] addr_bits;
        logic [3:0] dummy;
        logic is_read;
        logic [2:0] out_w;
        logic [1:0] src;
        logic is_din;
        logic is_op;
    } sfe_decode_t;

endpackage

// ### sfe_spi_master.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_spi_master (
    input wire logic clk_in,
    input wire logic [3:0] data_line_out,
    input wire logic [3:0] data_line_oe_out,
    output logic cs_n_out = 1'b0,
    output logic sclk_out = 1'b0,
    output logic [3:0] line_out
);
    logic [3:0] drv_r = 4'hF;
    // Released lanes 0 and 1 carry noise in the read phase (2 and 3 only for quad, else high) so stale data never passes
    assign line_out = (data_line_oe_out & data_line_out) | (~data_line_oe_out & drv_r);
    task automatic half();
        repeat (4) @(posedge clk_in);
    endtask
    // idle level, then select low (a fresh fall only after a previous call left it high), opcode first
    task automatic xfer(input bit m3, input logic [31:0] tx, input int nt, input int nr,
                        input int w, input bit p, output logic [15:0] rx, output logic [3:0] oe);
        logic [31:0] r;
        rx = 16'h0;
        oe = 4'h0;
        sclk_out <= m3;
        half();
        cs_n_out <= 1'b0;
        half();
        for (int i = 0; i < nt + nr; i++) begin
            r = $urandom;
            sclk_out <= 1'b0;
            drv_r <= (i < nt) ? {3'h7, tx[31 - i]} : {(w == 4) ? r[3:2] : 2'h3, r[1:0]};
            half();
            if (p && i == 4) begin
                drv_r[3] <= 1'b0;
                half();
                sclk_out <= 1'b1;
                half();
                sclk_out <= 1'b0;
                half();
                drv_r[3] <= 1'b1;
                half();
            end
            sclk_out <= 1'b1;
            half();
            rx = (rx << w) | ((w == 1) ? 16'(line_out[1]) : 16'(line_out & 4'((1 << w) - 1)));
            oe |= data_line_oe_out;
        end
        sclk_out <= m3;
        half();
        cs_n_out <= 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

// ### sfe_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module sfe_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } sfe_sync_t;

    sfe_sync_t s_r;
    sfe_sync_t s_nxt;

    always_comb begin
        s_nxt.meta = d_in;
        s_nxt.q = s_r.meta;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s_r <= '0;
        end else if (ce_in) begin
            s_r <= s_nxt;
        end
    end

    assign q_out = s_r.q;
endmodule
`default_nettype wire
